//--- verilog/pwr_consts.svh
`ifndef PWR_CONSTS_SVH
`define PWR_CONSTS_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define PWR_OFS_RESET_FLAGS 16'h1800
`define PWR_OFS_TIMER_CTRL 16'h1804
`define PWR_OFS_OPTION 16'h1808

// ****************************************************************
// Timer control and status fields
// ****************************************************************
`define PWR_TIMER_FLAG_BIT 7
`define PWR_TIMER_ACK_BIT 6
`define PWR_TIMER_CLKSEL_BIT 5
`define PWR_TIMER_IRQEN_BIT 4
`define PWR_TIMER_PERIOD_HI 2
`define PWR_TIMER_PERIOD_LO 0

// ****************************************************************
// Reset source flag fields
// ****************************************************************
`define PWR_FLAG_POR_BIT 7
`define PWR_FLAG_PIN_BIT 6
`define PWR_FLAG_WDOG_BIT 5
`define PWR_FLAG_BADOP_BIT 4
`define PWR_FLAG_BADADDR_BIT 3
`define PWR_FLAG_WAKEUNIT_BIT 2
`define PWR_FLAG_LOWV_BIT 1

// ****************************************************************
// Option fields
// ****************************************************************
`define PWR_OPT_TEMP_EN_BIT 3
`define PWR_OPT_TEMP_LEVEL_BIT 2

// ****************************************************************
// Reset values
// ****************************************************************
`define PWR_FLAGS_POR_VALUE 8'h82
`define PWR_TIMER_CTRL_RESET 8'h00
`define PWR_OPTION_RESET 8'h00

`endif

//--- verilog/pwr_pkg.sv
package pwr_pkg;

    typedef logic [7:0] pwr_byte_t;

    typedef enum logic {
        pwr_src_slow,
        pwr_src_fast
    } pwr_clk_src_t;

endpackage

//--- verilog/pwr_tick_div.sv
`timescale 1ns/1ps

module pwr_tick_div #(
    parameter int CNT_W = 8,
    parameter int SEL_W = 3
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clear,
    input wire logic tick,
    input wire logic [SEL_W-1:0] period_sel,
    output logic expire
);

    // ****************************************************************
    // Period counter
    // ****************************************************************
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] limit;
    logic [CNT_W-1:0] next_count;

    if (CNT_W < (2 ** SEL_W) - 1) begin : g_bad_width
        $error("Counter too narrow for the longest period.");
    end

    assign limit = CNT_W'(1) << period_sel;
    assign next_count = count + CNT_W'(1);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count <= '0;
            expire <= 1'b0;
        end else if (clear || period_sel == '0) begin
            count <= '0;
            expire <= 1'b0;
        end else if (tick && next_count == limit) begin
            count <= '0;
            expire <= 1'b1;
        end else begin
            count <= tick ? next_count : count;
            expire <= 1'b0;
        end
    end

endmodule

//--- verilog/pwr_sysctl.sv
// What this block does
// - Timer ticks from low-frequency oscillator, or high-frequency one in run mode.
// - Timer flag sets on each timer event, clears by acknowledge write, reset.
// - Acknowledge bit reads zero; writing one clears the timer flag.
// - Interrupt enable gates the timer interrupt request; reset clears it.
// - Period field: zero stops, else 2 to 128 oscillator ticks.
// - Timer works as run-mode interrupt and as wakeup from low-power modes.
// - No control can stop the low-frequency oscillator feeding the timer.
// - Temperature restart in deepest stop wakes the part, then resets it.
// - Software enables restart first; level bit picks cold or hot return.
// - Reset source register at 0x1800 holds seven read-only flags.
// - Debug-forced reset leaves every reset source flag cleared.
// - Writing the reset source address restarts watchdog, flags unchanged.
// - Power-on or low-voltage reset gives 0x82; others record active sources.
// - Pin flag set by low reset pin, not while in deepest stop.
// - Watchdog flag records timeouts; source blocked while watchdog disabled.
// - Bad opcode flag includes disabled stop and disabled background instruction.
// - Bad address flag records access to unimplemented memory.
// - Wakeup-unit flag records its reset except after deepest stop exit.
// - Low-voltage flag set by low-voltage trip with reset and stop enables both set, and by power-on.
// - Bit 0 of the reset source register always reads zero.
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "pwr_consts.svh"

module pwr_sysctl #(
    parameter int PERIOD_CNT_W = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic low_freq_osc_tick,
    input wire logic high_freq_osc_tick,
    input wire logic run_mode,
    input wire logic deepest_stop_mode,
    input wire logic power_on_event,
    input wire logic low_voltage_trip,
    input wire logic low_voltage_reset_enable,
    input wire logic low_voltage_stop_enable,
    input wire logic reset_pin_n,
    input wire logic watchdog_timeout,
    input wire logic watchdog_enable,
    input wire logic bad_opcode_event,
    input wire logic stop_instr_exec,
    input wire logic stop_instruction_enable,
    input wire logic background_instr_exec,
    input wire logic background_debug_enable,
    input wire logic bad_address_event,
    input wire logic wakeup_unit_reset,
    input wire logic debug_forced_reset,
    input wire logic temp_very_low,
    input wire logic temp_very_high,
    output logic timer_irq,
    output logic timer_wakeup,
    output logic temp_wakeup,
    output logic mcu_reset,
    output logic watchdog_restart
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    pwr_pkg::pwr_byte_t reset_flags;
    pwr_pkg::pwr_byte_t next_flags;
    pwr_pkg::pwr_byte_t rd_value;
    pwr_pkg::pwr_clk_src_t timer_clock_select;
    logic timer_flag;
    logic timer_irq_enable;
    logic [2:0] timer_period_select;
    logic temp_restart_enable;
    logic temp_restart_level;
    logic temp_was_out;
    logic temp_out_now;
    logic sel_flags;
    logic sel_ctrl;
    logic sel_opt;
    logic wr_done;
    logic rd_start;
    logic pin_src;
    logic wdog_src;
    logic op_src;
    logic wu_src;
    logic lv_src;
    logic any_src;
    logic timer_tick;
    logic expire;
    logic ack_write;

    // Seven bits are the least that still reach the longest period, by wrapping to zero.
    if (PERIOD_CNT_W < 7) begin : g_bad_cnt_w
        $error("Period counter narrower than seven bits.");
    end

    // ****************************************************************
    // Register bus
    // ****************************************************************
    assign sel_flags = avs_address == `PWR_OFS_RESET_FLAGS;
    assign sel_ctrl = avs_address == `PWR_OFS_TIMER_CTRL;
    assign sel_opt = avs_address == `PWR_OFS_OPTION;
    assign wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign rd_start = avs_read && avs_waitrequest;
    assign ack_write = wr_done && sel_ctrl && avs_writedata[`PWR_TIMER_ACK_BIT];

    // A request always stalls one cycle so read data come from a flop.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    always_comb begin
        rd_value = '0;
        if (sel_flags) begin
            rd_value = reset_flags & 8'hfe;
        end else if (sel_ctrl) begin
            rd_value[`PWR_TIMER_FLAG_BIT] = timer_flag;
            rd_value[`PWR_TIMER_ACK_BIT] = 1'b0;
            rd_value[`PWR_TIMER_CLKSEL_BIT] = timer_clock_select == pwr_pkg::pwr_src_fast;
            rd_value[`PWR_TIMER_IRQEN_BIT] = timer_irq_enable;
            rd_value[`PWR_TIMER_PERIOD_HI:`PWR_TIMER_PERIOD_LO] = timer_period_select;
        end else if (sel_opt) begin
            rd_value[`PWR_OPT_TEMP_EN_BIT] = temp_restart_enable;
            rd_value[`PWR_OPT_TEMP_LEVEL_BIT] = temp_restart_level;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            avs_readdata <= '0;
        end else if (rd_start) begin
            avs_readdata <= {24'h000000, rd_value};
        end
    end

    // ****************************************************************
    // Reset sources
    // ****************************************************************
    assign pin_src = !reset_pin_n;
    assign wdog_src = watchdog_timeout && watchdog_enable;
    assign op_src = bad_opcode_event
        || (stop_instr_exec && !stop_instruction_enable)
        || (background_instr_exec && !background_debug_enable);
    assign wu_src = wakeup_unit_reset && !deepest_stop_mode;
    assign lv_src = power_on_event
        || (low_voltage_trip && low_voltage_reset_enable && low_voltage_stop_enable);
    // A wakeup-unit reset still resets in deepest stop; only its flag is withheld.
    assign any_src = pin_src || wdog_src || op_src || bad_address_event
        || wakeup_unit_reset || lv_src || temp_wakeup || debug_forced_reset;

    always_comb begin
        next_flags = '0;
        if (debug_forced_reset) begin
            next_flags = '0;
        end else if (lv_src) begin
            next_flags = `PWR_FLAGS_POR_VALUE;
        end else begin
            next_flags[`PWR_FLAG_PIN_BIT] = pin_src && !deepest_stop_mode;
            next_flags[`PWR_FLAG_WDOG_BIT] = wdog_src;
            next_flags[`PWR_FLAG_BADOP_BIT] = op_src;
            next_flags[`PWR_FLAG_BADADDR_BIT] = bad_address_event;
            next_flags[`PWR_FLAG_WAKEUNIT_BIT] = wu_src;
        end
    end

    // Flags only change on a reset event, so a bus write never alters them.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reset_flags <= `PWR_FLAGS_POR_VALUE;
        end else if (any_src) begin
            reset_flags <= next_flags;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mcu_reset <= 1'b0;
        end else begin
            mcu_reset <= any_src;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            watchdog_restart <= 1'b0;
        end else begin
            watchdog_restart <= wr_done && sel_flags;
        end
    end

    // ****************************************************************
    // Periodic wakeup timer
    // ****************************************************************
    // The slow tick has no enable anywhere in this block, so it keeps running.
    assign timer_tick = (timer_clock_select == pwr_pkg::pwr_src_fast)
        ? (high_freq_osc_tick && run_mode) : low_freq_osc_tick;

    pwr_tick_div #(
        .CNT_W(PERIOD_CNT_W),
        .SEL_W(3)
    ) u_div (
        .clk_sys(clk_sys),
        .rst(rst),
        .clear(any_src),
        .tick(timer_tick),
        .period_sel(timer_period_select),
        .expire(expire)
    );

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            timer_flag <= 1'b0;
        end else if (any_src) begin
            timer_flag <= 1'b0;
        end else if (expire) begin
            timer_flag <= 1'b1;
        end else if (ack_write) begin
            timer_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            timer_irq_enable <= 1'b0;
            timer_period_select <= 3'h0;
            timer_clock_select <= pwr_pkg::pwr_src_slow;
        end else if (any_src) begin
            timer_irq_enable <= 1'b0;
            timer_period_select <= 3'h0;
            timer_clock_select <= pwr_pkg::pwr_src_slow;
        end else if (wr_done && sel_ctrl) begin
            timer_irq_enable <= avs_writedata[`PWR_TIMER_IRQEN_BIT];
            timer_period_select <= avs_writedata[`PWR_TIMER_PERIOD_HI:`PWR_TIMER_PERIOD_LO];
            timer_clock_select <= pwr_pkg::pwr_clk_src_t'(avs_writedata[`PWR_TIMER_CLKSEL_BIT]);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            timer_irq <= 1'b0;
            timer_wakeup <= 1'b0;
        end else begin
            timer_irq <= timer_flag && timer_irq_enable && !any_src;
            timer_wakeup <= expire;
        end
    end

    // ****************************************************************
    // Temperature restart
    // ****************************************************************
    // Software must arm this before entering deepest stop; nothing checks it.
    assign temp_out_now = temp_restart_level ? temp_very_high : temp_very_low;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            temp_restart_enable <= 1'b0;
            temp_restart_level <= 1'b0;
        end else if (any_src) begin
            temp_restart_enable <= 1'b0;
            temp_restart_level <= 1'b0;
        end else if (wr_done && sel_opt) begin
            temp_restart_enable <= avs_writedata[`PWR_OPT_TEMP_EN_BIT];
            temp_restart_level <= avs_writedata[`PWR_OPT_TEMP_LEVEL_BIT];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            temp_was_out <= 1'b0;
        end else begin
            temp_was_out <= temp_out_now;
        end
    end

    // The wakeup pulse is itself a reset source on the next edge.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            temp_wakeup <= 1'b0;
        end else begin
            temp_wakeup <= deepest_stop_mode && temp_restart_enable
                && temp_was_out && !temp_out_now;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    flag_set_a: assert property (expire && !any_src |=> timer_flag)
        else $error("Timer flag not set by timer event.");

    ack_clear_a: assert property (
        ack_write && timer_flag && !expire && !any_src |=> !timer_flag)
        else $error("Acknowledge did not clear timer flag.");

    ack_reads_a: assert property (
        avs_read && !avs_waitrequest && sel_ctrl |-> !avs_readdata[6])
        else $error("Acknowledge bit read as one.");

    irq_gate_a: assert property (timer_irq |-> $past(timer_irq_enable))
        else $error("Timer interrupt raised while disabled.");

    period_off_a: assert property (
        (timer_period_select == 3'h0) [*2] |-> !expire ##1 !timer_wakeup)
        else $error("Timer fired while stopped.");

    fast_run_a: assert property (
        timer_clock_select == pwr_pkg::pwr_src_fast && !run_mode |=> !expire)
        else $error("Fast clock ticked outside run mode.");

    temp_reset_a: assert property (temp_wakeup |=> mcu_reset ##0 reset_flags == 8'h00
        || $past(lv_src))
        else $error("Temperature wakeup did not reset.");

    debug_clear_a: assert property (debug_forced_reset |=> reset_flags == 8'h00)
        else $error("Debug reset left a flag set.");

    wdog_write_a: assert property (
        wr_done && sel_flags && !any_src |=> watchdog_restart && $stable(reset_flags))
        else $error("Status write misbehaved.");

    lowv_value_a: assert property (lv_src && !debug_forced_reset |=> reset_flags == 8'h82)
        else $error("Power-on flags wrong.");

    pin_stop_a: assert property (
        deepest_stop_mode && !reset_pin_n |=> !reset_flags[6] && mcu_reset)
        else $error("Pin flag set in deepest stop.");

    bit_zero_a: assert property (
        avs_read && !avs_waitrequest && sel_flags |-> !avs_readdata[0])
        else $error("Reset flag bit zero read as one.");

endmodule

//--- dv/tb_pwr_sysctl.sv
`timescale 1ns/1ps
`include "pwr_consts.svh"

module tb_pwr_sysctl;
    // ****************************************************************
    // Stimulus, design and event counters
    // ****************************************************************
    localparam logic [15:0] A_FLG = `PWR_OFS_RESET_FLAGS;
    localparam logic [15:0] A_TMR = `PWR_OFS_TIMER_CTRL;
    localparam logic [15:0] A_OPT = `PWR_OFS_OPTION;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [15:0] avs_address = 16'h0000;
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, timer_irq, timer_wakeup, temp_wakeup, mcu_reset, watchdog_restart;
    logic low_freq_osc_tick = 1'b0, high_freq_osc_tick = 1'b0, run_mode = 1'b1;
    logic deepest_stop_mode = 1'b0, power_on_event = 1'b0, low_voltage_trip = 1'b0;
    logic low_voltage_reset_enable = 1'b0, low_voltage_stop_enable = 1'b0, reset_pin_n = 1'b1;
    logic watchdog_timeout = 1'b0, watchdog_enable = 1'b1, bad_opcode_event = 1'b0;
    logic stop_instr_exec = 1'b0, stop_instruction_enable = 1'b1, background_instr_exec = 1'b0;
    logic background_debug_enable = 1'b1, bad_address_event = 1'b0, wakeup_unit_reset = 1'b0;
    logic debug_forced_reset = 1'b0, temp_very_low = 1'b0, temp_very_high = 1'b0;
    int fail_count = 0, cmp_count = 0, n_tw = 0, n_tmp = 0, n_rst = 0, n_wd = 0;
    int m_flags;
    int unsigned rng = 32'd68677;
    logic [31:0] d;
    logic [7:0] ctl;
    int b_t, b_r;
    // Sources that cause no reset at all are marked with -1.
    int exp_tab[15] = '{8'h40, 8'h20, -1, 8'h10, 8'h10, -1, 8'h10, 8'h08, 8'h04, 8'h00,
                        8'h82, 8'h82, -1, 8'h00, 8'h28};

    pwr_sysctl u_pwr_sysctl (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .low_freq_osc_tick,
        .high_freq_osc_tick, .run_mode, .deepest_stop_mode, .power_on_event, .low_voltage_trip,
        .low_voltage_reset_enable, .low_voltage_stop_enable, .reset_pin_n, .watchdog_timeout,
        .watchdog_enable, .bad_opcode_event, .stop_instr_exec, .stop_instruction_enable,
        .background_instr_exec, .background_debug_enable, .bad_address_event, .wakeup_unit_reset,
        .debug_forced_reset, .temp_very_low, .temp_very_high, .timer_irq, .timer_wakeup,
        .temp_wakeup, .mcu_reset, .watchdog_restart);

    always #2.5 clk_sys = ~clk_sys;

    // Pulses are counted on the falling edge, so the count never races the sequence.
    always @(negedge clk_sys) begin
        n_tw += (timer_wakeup === 1'b1);
        n_tmp += (temp_wakeup === 1'b1);
        n_rst += (mcu_reset === 1'b1);
        n_wd += (watchdog_restart === 1'b1);
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    function automatic int unsigned rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    task automatic finish_test();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic rd, input logic [15:0] adr, input logic [31:0] wd,
                       output logic [31:0] q);
        int guard;
        guard = 0;
        @(posedge clk_sys);
        avs_address <= adr;
        avs_read <= rd;
        avs_write <= !rd;
        avs_writedata <= wd;
        avs_byteenable <= 4'h1;
        do begin
            @(posedge clk_sys);
            guard++;
        end while (avs_waitrequest !== 1'b0 && guard < 50);
        chk("bus_wait", avs_waitrequest, 32'h0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] adr, input logic [31:0] wd);
        bus(1'b0, adr, wd, d);
    endtask

    task automatic rdchk(input string what, input logic [15:0] adr, input logic [31:0] exp);
        bus(1'b1, adr, 32'h0, d);
        chk(what, d, exp);
    endtask

    task automatic ticks(input int cnt, input logic fast);
        repeat (cnt) begin
            @(posedge clk_sys);
            if (fast) high_freq_osc_tick <= 1'b1;
            else low_freq_osc_tick <= 1'b1;
            @(posedge clk_sys);
            high_freq_osc_tick <= 1'b0;
            low_freq_osc_tick <= 1'b0;
        end
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic idle();
        {reset_pin_n, watchdog_enable, stop_instruction_enable} <= 3'h7;
        {background_debug_enable, run_mode, deepest_stop_mode} <= 3'h6;
        {watchdog_timeout, bad_opcode_event, stop_instr_exec, background_instr_exec} <= 4'h0;
        {bad_address_event, wakeup_unit_reset, debug_forced_reset, power_on_event} <= 4'h0;
        {low_voltage_trip, low_voltage_reset_enable, low_voltage_stop_enable} <= 3'h0;
    endtask

    task automatic src(input int k);
        @(posedge clk_sys);
        case (k)
            0: reset_pin_n <= 1'b0;
            1: watchdog_timeout <= 1'b1;
            2: {watchdog_enable, watchdog_timeout} <= 2'h1;
            3: bad_opcode_event <= 1'b1;
            4: {stop_instruction_enable, stop_instr_exec} <= 2'h1;
            5: stop_instr_exec <= 1'b1;
            6: {background_debug_enable, background_instr_exec} <= 2'h1;
            7: bad_address_event <= 1'b1;
            8: wakeup_unit_reset <= 1'b1;
            9: debug_forced_reset <= 1'b1;
            10: power_on_event <= 1'b1;
            11: {low_voltage_reset_enable, low_voltage_stop_enable, low_voltage_trip} <= 3'h7;
            12: {low_voltage_stop_enable, low_voltage_trip} <= 2'h3;
            13: {deepest_stop_mode, run_mode, reset_pin_n} <= 3'h4;
            default: {watchdog_timeout, bad_address_event} <= 2'h3;
        endcase
        @(posedge clk_sys);
        idle();
        repeat (3) @(posedge clk_sys);
    endtask

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        #200us;
        fail_count++;
        finish_test();
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        m_flags = 8'h82;
        rdchk("flags_por", A_FLG, m_flags);
        rdchk("ctrl_por", A_TMR, 32'h0);
        rdchk("opt_por", A_OPT, 32'h0);
        wr(16'h1810, rnd());
        rdchk("unmapped", 16'h1810, 32'h0);
        ticks(5, 1'b0);
        rdchk("period_off", A_TMR, 32'h0);
        // Odd periods run with the interrupt enabled, even ones in deepest stop.
        for (int n = 1; n <= 7; n++) begin
            run_mode <= n[0];
            deepest_stop_mode <= !n[0];
            wr(A_TMR, 32'h0);
            ctl = {3'h0, n[0], 1'b0, n[2:0]};
            wr(A_TMR, ctl);
            b_t = n_tw;
            ticks((1 << n) - 1, 1'b0);
            rdchk("ctrl_early", A_TMR, ctl);
            ticks(1, 1'b0);
            rdchk("ctrl_flag", A_TMR, ctl | 8'h80);
            chk("timer_irq", timer_irq, n % 2);
            chk("wakeups", n_tw - b_t, 32'h1);
            wr(A_TMR, ctl);
            rdchk("flag_w0", A_TMR, ctl | 8'h80);
            wr(A_TMR, ctl | 8'h40);
            rdchk("ctrl_ack", A_TMR, ctl);
        end
        idle();
        wr(A_TMR, 32'h0);
        wr(A_TMR, 8'h31);
        ticks(4, 1'b0);
        rdchk("fast_sel_slow", A_TMR, 8'h31);
        run_mode <= 1'b0;
        ticks(2, 1'b1);
        rdchk("fast_not_run", A_TMR, 8'h31);
        run_mode <= 1'b1;
        ticks(2, 1'b1);
        rdchk("fast_sel", A_TMR, 8'hb1);
        chk("fast_irq", timer_irq, 32'h1);
        wr(A_TMR, 8'h40);
        for (int k = 0; k < 15; k++) begin
            wr(A_TMR, 8'h14);
            b_r = n_rst;
            src(k);
            chk("resets", n_rst - b_r, exp_tab[k] >= 0);
            if (exp_tab[k] >= 0) m_flags = exp_tab[k];
            rdchk("flags", A_FLG, m_flags);
            rdchk("ctrl_rst", A_TMR, exp_tab[k] >= 0 ? 32'h0 : 32'h14);
        end
        // Writes to the status address restart the watchdog only.
        repeat (3) begin
            b_t = n_wd;
            wr(A_FLG, rnd());
            repeat (3) @(posedge clk_sys);
            chk("wd_restart", n_wd - b_t, 32'h1);
            rdchk("flags_ro", A_FLG, m_flags);
        end
        for (int lvl = 0; lvl < 2; lvl++) begin
            deepest_stop_mode <= 1'b1;
            run_mode <= 1'b0;
            wr(A_OPT, 8'h08 | (lvl << 2));
            rdchk("opt", A_OPT, 8'h08 | (lvl << 2));
            b_t = n_tmp;
            b_r = n_rst;
            {temp_very_high, temp_very_low} <= lvl ? 2'h1 : 2'h2;
            repeat (4) @(posedge clk_sys);
            {temp_very_high, temp_very_low} <= 2'h0;
            repeat (4) @(posedge clk_sys);
            chk("no_wake", n_tmp - b_t, 32'h0);
            {temp_very_high, temp_very_low} <= lvl ? 2'h2 : 2'h1;
            repeat (4) @(posedge clk_sys);
            {temp_very_high, temp_very_low} <= 2'h0;
            repeat (4) @(posedge clk_sys);
            chk("temp_wake", n_tmp - b_t, 32'h1);
            chk("temp_reset", n_rst - b_r, 32'h1);
            m_flags = 0;
            idle();
            rdchk("temp_flags", A_FLG, m_flags);
            rdchk("opt_rst", A_OPT, 32'h0);
        end
        finish_test();
    end
endmodule
